// >>> hw/cldc_top.sv
// console link and dump control state machine
// ---------------------------------------------------------------
// What this block does
// [R1] start dump out on keys or request
// [R2] flash indicator, send 128 scenes plus groups
// [R3] refuse dump out unless normal, not dumping in
// [R4] automation off during dump out, then resume
// [R5] no mute sends, drop midi during out
// [R6] dump in only on own-format packet
// [R7] checksum each packet, write or flag error
// [R8] leave dump in after 1s silence
// [R9] flash dump-in indicator, no mute sends
// [R10] packets accepted in any order
// [R11] dump request never enters dump in
// [R12] ignore dump in during preview, solo, out
// [R13] boot cable test picks one of three roles
// [R14] slave inherits settings, flashes wait indicator
// [R15] slave ignores automation except solo controls
// [R16] slave up+down+recall starts local dump out
// [R17] link only when master in normal mode
// [R18] clear all solos on link establish
// [R19] slave copies display, reapplies group mutes
// [R20] hello exchange every 10s while linked
// [R21] timeout clears solos, slave waits, limited
// [R22] relink resyncs; after 30s become independent
// [R23] master calls hello, slave replies, period timeout
// ---------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
module cldc_top
	import cldc_pkg::*;
#(
	parameter int DUMP_IDLE_TICKS = CLDC_DUMP_IDLE_TICKS,
	parameter int HELLO_TICKS = CLDC_HELLO_TICKS,
	parameter int RELINK_TICKS = CLDC_RELINK_TICKS,
	parameter int TICK_DIV = CLDC_TICK_DIV
) (
	input wire logic CLK,
	input wire logic RESET_N,
	// register port
	input wire logic [3:0] REG_ADDR,
	input wire logic [7:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	output logic [7:0] REG_RDATA,
	// front panel keys, already debounced on this clock
	input wire logic KEY_YES,
	input wire logic KEY_NO,
	input wire logic KEY_UP,
	input wire logic KEY_DOWN,
	input wire logic KEY_RECALL,
	// midi receive decoder events
	input wire logic RX_SYSEX,
	input wire logic RX_DUMP_REQ,
	input wire logic RX_OWN_DUMP,
	input wire logic RX_CHECK_OK,
	input wire logic RX_MIDI_ANY,
	// midi transmit side
	output logic TX_PKT_VALID,
	output logic TX_PKT_GROUPS,
	output logic [6:0] TX_PKT_INDEX,
	input wire logic TX_PKT_READY,
	output logic MUTE_TX_ENABLE,
	output logic MIDI_RX_ENABLE,
	output logic MEM_WRITE,
	output logic ERROR_SHOW,
	// cascade link, cable sense and hello messages
	input wire logic CABLE_SENSE,
	input wire logic CABLE_TO_MASTER,
	input wire logic PEER_HELLO,
	input wire logic PEER_REPLY,
	input wire logic PEER_SYNC_DONE,
	output logic SEND_HELLO,
	output logic SEND_REPLY,
	output logic SYNC_REQUEST,
	output logic SOLO_CLEAR,
	output logic APPLY_GROUP_MUTES,
	output logic COPY_DISPLAY,
	// indicators and modes
	output logic DUMP_OUT_INDICATOR,
	output logic DUMP_IN_INDICATOR,
	output logic SLAVE_WAIT_INDICATOR,
	output logic SHOW_SCENE,
	output logic AUTOMATION_ENABLE,
	output logic SOLO_CTRL_ENABLE,
	output logic SLAVE_LEAVE_MODES,
	output logic [1:0] ROLE
);

	// ---------------------------------------------------------------
	// pin synchroniser for the cable sense and orientation
	// ---------------------------------------------------------------
	logic [2:0] sense_sync;
	logic [2:0] dir_sync;
	logic sense_ok;
	logic dir_ok;
	logic sense_stable;
	logic [2:0] sync_fill;

	// the stages hold reset zeros until filled; boot must not judge those
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			sense_sync <= 3'h0;
			dir_sync <= 3'h0;
			sync_fill <= 3'h0;
		end else begin
			sense_sync <= {sense_sync[1:0], CABLE_SENSE};
			dir_sync <= {dir_sync[1:0], CABLE_TO_MASTER};
			sync_fill <= {sync_fill[1:0], 1'b1};
		end
	end
	assign sense_stable = sync_fill[2] && sense_sync[1] == sense_sync[2] &&
		dir_sync[1] == dir_sync[2];
	assign sense_ok = sense_sync[2];
	assign dir_ok = dir_sync[2];

	// ---------------------------------------------------------------
	// millisecond tick and flash rate
	// ---------------------------------------------------------------
	logic [15:0] div_cnt;
	logic tick;
	logic [7:0] flash_cnt;
	logic flash;

	assign tick = div_cnt == 16'(TICK_DIV - 1);
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			div_cnt <= 16'h0000;
			flash_cnt <= 8'h00;
			flash <= 1'b0;
		end else begin
			div_cnt <= tick ? 16'h0000 : div_cnt + 16'h0001;
			if (tick) begin
				if (flash_cnt == 8'(CLDC_FLASH_TICKS - 1)) begin
					flash_cnt <= 8'h00;
					flash <= ~flash;
				end else begin
					flash_cnt <= flash_cnt + 8'h01;
				end
			end
		end
	end

	// ---------------------------------------------------------------
	// control register
	// ---------------------------------------------------------------
	logic [7:0] ctrl;
	logic [7:0] pkt_cnt;
	logic [7:0] err_cnt;
	logic normal_mode;
	logic master_normal;

	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N)
			ctrl <= 8'h00;
		else if (REG_WR && REG_ADDR == CLDC_REG_CTRL)
			ctrl <= REG_WDATA;
	end
	assign normal_mode = !ctrl[CLDC_CTRL_SCROLL] && !ctrl[CLDC_CTRL_STORE];

	// ---------------------------------------------------------------
	// dump state machine
	// ---------------------------------------------------------------
	cldc_dump_t dump;
	cldc_dump_t next_dump;
	cldc_role_t role;
	cldc_link_t link;
	logic [7:0] out_idx;
	logic [11:0] idle_cnt;
	logic key_dump;
	logic start_out;
	logic start_in;
	logic out_last;
	logic out_step;

	// slave uses up+down+recall, master/standalone yes+no+recall
	assign key_dump = role == CLDC_ROLE_SLAVE ?
		(KEY_UP && KEY_DOWN && KEY_RECALL) : // R16
		(KEY_YES && KEY_NO && KEY_RECALL); // R1
	assign start_out = (key_dump || (RX_SYSEX && RX_DUMP_REQ)) &&
		normal_mode; // R1 R3
	assign start_in = RX_SYSEX && RX_OWN_DUMP && !RX_DUMP_REQ && // R6 R11
		!ctrl[CLDC_CTRL_PREVIEW] && !ctrl[CLDC_CTRL_SIP]; // R12
	assign out_step = TX_PKT_VALID && TX_PKT_READY;
	assign out_last = out_idx == CLDC_SCENE_PACKETS; // R2

	always_comb begin
		next_dump = dump;
		case (dump)
			CLDC_D_IDLE: begin
				if (start_out)
					next_dump = CLDC_D_OUT;
				else if (start_in)
					next_dump = CLDC_D_IN;
			end
			CLDC_D_OUT: begin
				if (out_step && out_last)
					next_dump = CLDC_D_IDLE; // R4
			end
			CLDC_D_IN: begin
				if (idle_cnt == 12'(DUMP_IDLE_TICKS) && !RX_SYSEX)
					next_dump = CLDC_D_IDLE; // R8
			end
			default: next_dump = CLDC_D_IDLE;
		endcase
	end

	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			dump <= CLDC_D_IDLE;
			out_idx <= 8'h00;
			idle_cnt <= 12'h000;
			pkt_cnt <= 8'h00;
			err_cnt <= 8'h00;
		end else begin
			dump <= next_dump;
			if (dump != CLDC_D_OUT)
				out_idx <= 8'h00;
			else if (out_step)
				out_idx <= out_idx + 8'h01; // R2
			if (dump != CLDC_D_IN || RX_SYSEX)
				idle_cnt <= 12'h000; // R8
			else if (tick)
				idle_cnt <= idle_cnt + 12'h001;
			// any packet order is accepted: only count it
			if (MEM_WRITE)
				pkt_cnt <= pkt_cnt + 8'h01; // R10
			if (ERROR_SHOW)
				err_cnt <= err_cnt + 8'h01;
		end
	end

	assign TX_PKT_VALID = dump == CLDC_D_OUT;
	assign TX_PKT_GROUPS = out_last;
	assign TX_PKT_INDEX = out_idx[6:0];
	// an own-format packet in dump in, or the one that starts it
	logic in_pkt;
	assign in_pkt = RX_SYSEX && RX_OWN_DUMP && !RX_DUMP_REQ &&
		(dump == CLDC_D_IN || (dump == CLDC_D_IDLE && start_in && !start_out));
	assign MEM_WRITE = in_pkt && RX_CHECK_OK; // R7
	assign ERROR_SHOW = in_pkt && !RX_CHECK_OK; // R7
	assign MUTE_TX_ENABLE = dump == CLDC_D_IDLE; // R5 R9
	assign MIDI_RX_ENABLE = dump != CLDC_D_OUT; // R5
	assign DUMP_OUT_INDICATOR = dump == CLDC_D_OUT && flash; // R2
	assign DUMP_IN_INDICATOR = dump == CLDC_D_IN && flash; // R9
	assign SHOW_SCENE = dump == CLDC_D_IDLE &&
		link != CLDC_L_WAIT && link != CLDC_L_SYNC; // R4

	// ---------------------------------------------------------------
	// link state machine
	// ---------------------------------------------------------------
	cldc_link_t next_link;
	logic [14:0] hello_cnt;
	logic [14:0] lost_cnt;
	logic reply_seen;
	logic hello_due;

	assign master_normal = normal_mode && dump == CLDC_D_IDLE &&
		ctrl[CLDC_CTRL_EDIT:CLDC_CTRL_PREVIEW] == 3'h0 &&
		!ctrl[CLDC_CTRL_ASSIGN]; // R17
	// only the master paces hellos; the slave watch must run two periods
	assign hello_due = tick && hello_cnt == 15'(HELLO_TICKS - 1) &&
		role == CLDC_ROLE_MASTER;

	always_comb begin
		next_link = link;
		case (link)
			CLDC_L_BOOT: begin
				if (sense_stable)
					next_link = sense_ok ? CLDC_L_WAIT : CLDC_L_ALONE; // R13
			end
			CLDC_L_WAIT: begin
				if (role == CLDC_ROLE_MASTER ? master_normal : PEER_SYNC_DONE)
					next_link = CLDC_L_SYNC; // R17
				else if (lost_cnt == 15'(RELINK_TICKS))
					next_link = CLDC_L_ALONE; // R22
			end
			CLDC_L_SYNC: next_link = CLDC_L_LINKED; // R19
			CLDC_L_LINKED: begin
				if (role == CLDC_ROLE_MASTER ?
					(hello_due && !reply_seen) : // R23
					(tick && hello_cnt == 15'(2 * HELLO_TICKS - 1)))
					next_link = CLDC_L_LOST; // R21
			end
			CLDC_L_LOST: next_link = CLDC_L_WAIT;
			CLDC_L_ALONE: next_link = CLDC_L_ALONE; // R22
			default: next_link = CLDC_L_BOOT;
		endcase
	end

	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			link <= CLDC_L_BOOT;
			role <= CLDC_ROLE_STANDALONE;
			hello_cnt <= 15'h0000;
			lost_cnt <= 15'h0000;
			reply_seen <= 1'b0;
		end else begin
			link <= next_link;
			if (link == CLDC_L_BOOT && sense_stable)
				role <= !sense_ok ? CLDC_ROLE_STANDALONE :
					dir_ok ? CLDC_ROLE_SLAVE : CLDC_ROLE_MASTER; // R13
			else if (next_link == CLDC_L_ALONE)
				role <= CLDC_ROLE_STANDALONE; // R22
			// slave restarts its watch on each hello heard
			if (link != CLDC_L_LINKED || hello_due ||
				(role == CLDC_ROLE_SLAVE && PEER_HELLO))
				hello_cnt <= 15'h0000; // R20
			else if (tick)
				hello_cnt <= hello_cnt + 15'h0001;
			// no hello is owed on entry; a reply at the period end wins
			if (link != CLDC_L_LINKED || PEER_REPLY)
				reply_seen <= 1'b1; // R23
			else if (hello_due)
				reply_seen <= 1'b0;
			// first boot wait also bounded by the relink window
			if (link != CLDC_L_WAIT)
				lost_cnt <= 15'h0000;
			else if (tick)
				lost_cnt <= lost_cnt + 15'h0001; // R22
		end
	end

	assign SEND_HELLO = link == CLDC_L_LINKED &&
		role == CLDC_ROLE_MASTER && hello_due; // R20 R23
	assign SEND_REPLY = link == CLDC_L_LINKED &&
		role == CLDC_ROLE_SLAVE && PEER_HELLO; // R23
	assign SYNC_REQUEST = link == CLDC_L_WAIT && role == CLDC_ROLE_SLAVE; // R14
	assign SOLO_CLEAR = link == CLDC_L_SYNC || link == CLDC_L_LOST; // R18 R21
	assign COPY_DISPLAY = link == CLDC_L_SYNC && role == CLDC_ROLE_SLAVE; // R19
	assign APPLY_GROUP_MUTES = COPY_DISPLAY; // R19
	assign SLAVE_LEAVE_MODES = link == CLDC_L_LOST &&
		role == CLDC_ROLE_SLAVE; // R21
	assign SLAVE_WAIT_INDICATOR = role == CLDC_ROLE_SLAVE &&
		(link == CLDC_L_WAIT || link == CLDC_L_SYNC) && flash; // R14 R21
	// slave keeps only solo controls, while waiting as well
	assign AUTOMATION_ENABLE = dump != CLDC_D_OUT &&
		role != CLDC_ROLE_SLAVE; // R4 R15 R21
	assign SOLO_CTRL_ENABLE = 1'b1; // R15
	assign ROLE = role;

	// ---------------------------------------------------------------
	// register read, one cycle latency
	// ---------------------------------------------------------------
	logic [7:0] rd_mux;
	assign rd_mux = REG_ADDR == CLDC_REG_CTRL ? ctrl :
		REG_ADDR == CLDC_REG_STATUS ? {1'b0, link, dump, role} :
		REG_ADDR == CLDC_REG_PKTCNT ? pkt_cnt :
		REG_ADDR == CLDC_REG_ERRCNT ? err_cnt : 8'h00;
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N)
			REG_RDATA <= 8'h00;
		else
			REG_RDATA <= REG_RD ? rd_mux : 8'h00;
	end

endmodule
`default_nettype wire

// >>> hw/cldc_pkg.sv
// constants and types shared by the console link and dump controller
package cldc_pkg;

	// ---------------------------------------------------------------
	// register map (word index = byte address / 4 not used: plain port)
	// ---------------------------------------------------------------
	localparam logic [3:0] CLDC_REG_CTRL = 4'h0;
	localparam logic [3:0] CLDC_REG_STATUS = 4'h1;
	localparam logic [3:0] CLDC_REG_PKTCNT = 4'h2;
	localparam logic [3:0] CLDC_REG_ERRCNT = 4'h3;

	// ctrl bit positions
	localparam int CLDC_CTRL_PREVIEW = 0;
	localparam int CLDC_CTRL_SIP = 1;
	localparam int CLDC_CTRL_EDIT = 2;
	localparam int CLDC_CTRL_ASSIGN = 3;
	localparam int CLDC_CTRL_SCROLL = 4;
	localparam int CLDC_CTRL_STORE = 5;

	// ---------------------------------------------------------------
	// dump geometry
	// ---------------------------------------------------------------
	localparam logic [7:0] CLDC_SCENE_PACKETS = 8'h80;

	// ---------------------------------------------------------------
	// timing
	// ---------------------------------------------------------------
	localparam longint CLDC_CLK_HZ = 40000000;
	localparam longint CLDC_DUMP_IDLE_MS = 1000;
	localparam longint CLDC_HELLO_MS = 10000;
	localparam longint CLDC_RELINK_MS = 30000;
	localparam longint CLDC_TICK_HZ = 1000;
	localparam int CLDC_TICK_DIV = int'(CLDC_CLK_HZ / CLDC_TICK_HZ);
	localparam int CLDC_DUMP_IDLE_TICKS = int'(CLDC_DUMP_IDLE_MS);
	localparam int CLDC_HELLO_TICKS = int'(CLDC_HELLO_MS);
	localparam int CLDC_RELINK_TICKS = int'(CLDC_RELINK_MS);
	localparam int CLDC_FLASH_TICKS = 250;

	// link roles
	typedef enum logic [1:0] {
		CLDC_ROLE_STANDALONE = 2'b00,
		CLDC_ROLE_MASTER = 2'b01,
		CLDC_ROLE_SLAVE = 2'b11
	} cldc_role_t;

	// dump state, gray along idle -> out -> in
	typedef enum logic [1:0] {
		CLDC_D_IDLE = 2'b00,
		CLDC_D_OUT = 2'b01,
		CLDC_D_IN = 2'b11
	} cldc_dump_t;

	// link state, gray along boot -> wait -> sync -> linked -> lost
	typedef enum logic [2:0] {
		CLDC_L_BOOT = 3'b000,
		CLDC_L_WAIT = 3'b001,
		CLDC_L_SYNC = 3'b011,
		CLDC_L_LINKED = 3'b010,
		CLDC_L_LOST = 3'b110,
		CLDC_L_ALONE = 3'b111
	} cldc_link_t;

endpackage

// >>> testbench/cldc_top_asserts.sv
// assertion checker on the ports of the link and dump controller
`timescale 1ns/1ps
`default_nettype none
module cldc_top_asserts
	import cldc_pkg::*;
#(
	parameter int HELLO_TICKS = CLDC_HELLO_TICKS,
	parameter int TICK_DIV = CLDC_TICK_DIV
) (
	input wire logic CLK,
	input wire logic RESET_N,
	input wire logic RX_SYSEX,
	input wire logic RX_DUMP_REQ,
	input wire logic RX_OWN_DUMP,
	input wire logic RX_CHECK_OK,
	input wire logic TX_PKT_VALID,
	input wire logic TX_PKT_GROUPS,
	input wire logic [6:0] TX_PKT_INDEX,
	input wire logic TX_PKT_READY,
	input wire logic MUTE_TX_ENABLE,
	input wire logic MIDI_RX_ENABLE,
	input wire logic MEM_WRITE,
	input wire logic ERROR_SHOW,
	input wire logic SEND_HELLO,
	input wire logic SEND_REPLY,
	input wire logic SOLO_CLEAR,
	input wire logic AUTOMATION_ENABLE,
	input wire logic [1:0] ROLE
);
	// ---------------------------------------------------------------
	// properties
	// ---------------------------------------------------------------
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RESET_N);
	// a sync or a loss restarts the hello phase, so the gap is unarmed
	localparam int GAP_LO = (HELLO_TICKS - 1) * TICK_DIV;
	localparam int GAP_HI = (HELLO_TICKS + 1) * TICK_DIV;
	int gap;
	logic armed;
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			gap <= 0;
			armed <= 1'b0;
		end else begin
			gap <= SEND_HELLO ? 1 : gap + 1;
			armed <= !SOLO_CLEAR && (SEND_HELLO || armed);
		end
	end
	sequence s_take;
		TX_PKT_VALID && TX_PKT_READY;
	endsequence
	property p_quiet;
		TX_PKT_VALID |-> !MUTE_TX_ENABLE && !MIDI_RX_ENABLE;
	endproperty
	a_quiet: assert property (p_quiet) else $error("midi open in dump");
	property p_auto;
		TX_PKT_VALID |-> !AUTOMATION_ENABLE && !MEM_WRITE && !ERROR_SHOW;
	endproperty
	a_auto: assert property (p_auto) else $error("active in dump");
	property p_hold;
		TX_PKT_VALID && !TX_PKT_READY |=> TX_PKT_VALID &&
			$stable({TX_PKT_GROUPS, TX_PKT_INDEX});
	endproperty
	a_hold: assert property (p_hold) else $error("packet changed");
	property p_step;
		s_take ##0 !TX_PKT_GROUPS |=> TX_PKT_VALID && (TX_PKT_GROUPS ?
			$past(TX_PKT_INDEX) == 7'h7F :
			TX_PKT_INDEX == $past(TX_PKT_INDEX) + 7'h01);
	endproperty
	a_step: assert property (p_step) else $error("bad packet order");
	property p_end;
		s_take ##0 TX_PKT_GROUPS |=> !TX_PKT_VALID && MUTE_TX_ENABLE;
	endproperty
	a_end: assert property (p_end) else $error("dump did not end");
	property p_groups;
		TX_PKT_GROUPS |-> TX_PKT_VALID && TX_PKT_INDEX == 7'h00;
	endproperty
	a_groups: assert property (p_groups) else $error("bad group packet");
	property p_write;
		MEM_WRITE || ERROR_SHOW |-> RX_SYSEX && RX_OWN_DUMP && !RX_DUMP_REQ
			&& MEM_WRITE == RX_CHECK_OK && ERROR_SHOW != RX_CHECK_OK;
	endproperty
	a_write: assert property (p_write) else $error("bad write");
	property p_caller;
		SEND_HELLO || SEND_REPLY |->
			ROLE == (SEND_HELLO ? CLDC_ROLE_MASTER : CLDC_ROLE_SLAVE);
	endproperty
	a_caller: assert property (p_caller) else $error("wrong caller");
	property p_gap;
		SEND_HELLO && armed |-> gap >= GAP_LO && gap <= GAP_HI;
	endproperty
	a_gap: assert property (p_gap) else $error("hello period off");
endmodule
`default_nettype wire

// >>> testbench/cldc_peer.sv
// far console and midi store model for the link and dump controller
`timescale 1ns/1ps
`default_nettype none
module cldc_peer
	import cldc_pkg::*;
(
	input wire logic clk,
	input wire logic reply_en,
	input wire logic [1:0] role,
	input wire logic send_hello,
	input wire logic sync_request,
	input wire logic pkt_valid,
	output logic peer_hello,
	output logic peer_reply,
	output logic peer_sync_done,
	output logic pkt_ready
);
	// ---------------------------------------------------------------
	// peer behaviour
	// ---------------------------------------------------------------
	// the store accepts on alternate cycles, so the source must hold
	int cnt = 0;
	initial {peer_hello, peer_reply, peer_sync_done, pkt_ready} = 4'h0;
	always @(posedge clk) begin
		cnt <= cnt + 1;
		pkt_ready <= pkt_valid && cnt[0];
		peer_reply <= reply_en && send_hello;
		// reply_en also silences the master's hello towards a slave
		peer_hello <= reply_en && role == CLDC_ROLE_SLAVE &&
			cnt % 32 == 0;
		peer_sync_done <= sync_request && cnt % 16 == 0;
	end
endmodule
`default_nettype wire

// >>> testbench/cldc_bench.sv
// self-checking bench for the link and dump controller
`timescale 1ns/1ps
`default_nettype none
`define CK(a, b) begin \
	total_checks++; \
	if ((a) !== (b)) begin \
		failures++; \
		$display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); \
	end \
end
module cldc_bench
	import cldc_pkg::*;
;
	// ---------------------------------------------------------------
	// stimulus and checks
	// ---------------------------------------------------------------
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [3:0] addr = 4'h0;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [4:0] key = 5'h00;
	logic [3:0] rx = 4'h0;
	logic to_master = 1'b0;
	logic reply_en = 1'b1;
	logic [7:0] rdata, d;
	logic ready, valid, groups, mute_en, mem_wr, err_show, p_hello, p_reply;
	logic p_sync, s_hello, s_reply, sync_req, solo_clr, copy_disp;
	logic show_scene, auto_en, solo_en, apply_gm, leave;
	logic cable = 1'b1;
	wire [2:0] ind;
	logic [6:0] idx;
	logic [1:0] role;
	logic [7:0] m [2];
	int failures = 0;
	int total_checks = 0;
	int n_hello = 0, n_reply = 0, n_solo = 0, n_copy = 0;
	int n_apply = 0, n_leave = 0;
	always #12.5 clk = ~clk;
	cldc_top #(.DUMP_IDLE_TICKS(5), .HELLO_TICKS(8), .RELINK_TICKS(20),
		.TICK_DIV(4)) u_cldc_top (.CLK(clk), .RESET_N(rst_n),
		.REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd),
		.REG_RDATA(rdata), .KEY_YES(key[4]), .KEY_NO(key[3]),
		.KEY_UP(key[2]), .KEY_DOWN(key[1]), .KEY_RECALL(key[0]),
		.RX_SYSEX(rx[3]), .RX_DUMP_REQ(rx[2]), .RX_OWN_DUMP(rx[1]),
		.RX_CHECK_OK(rx[0]), .RX_MIDI_ANY(1'b0), .TX_PKT_VALID(valid),
		.TX_PKT_GROUPS(groups), .TX_PKT_INDEX(idx), .TX_PKT_READY(ready),
		.MUTE_TX_ENABLE(mute_en), .MIDI_RX_ENABLE(), .MEM_WRITE(mem_wr),
		.ERROR_SHOW(err_show), .CABLE_SENSE(cable),
		.CABLE_TO_MASTER(to_master), .PEER_HELLO(p_hello),
		.PEER_REPLY(p_reply), .PEER_SYNC_DONE(p_sync), .SEND_HELLO(s_hello),
		.SEND_REPLY(s_reply), .SYNC_REQUEST(sync_req), .SOLO_CLEAR(solo_clr),
		.APPLY_GROUP_MUTES(apply_gm), .COPY_DISPLAY(copy_disp),
		.DUMP_OUT_INDICATOR(ind[2]), .DUMP_IN_INDICATOR(ind[1]),
		.SLAVE_WAIT_INDICATOR(ind[0]), .SHOW_SCENE(show_scene),
		.AUTOMATION_ENABLE(auto_en), .SOLO_CTRL_ENABLE(solo_en),
		.SLAVE_LEAVE_MODES(leave), .ROLE(role));
	cldc_peer u_cldc_peer (.clk(clk), .reply_en(reply_en), .role(role),
		.send_hello(s_hello), .sync_request(sync_req), .pkt_valid(valid),
		.peer_hello(p_hello), .peer_reply(p_reply), .peer_sync_done(p_sync),
		.pkt_ready(ready));
	always @(posedge clk) begin
		n_hello += (s_hello === 1'b1);
		n_reply += (s_reply === 1'b1);
		n_solo += (solo_clr === 1'b1);
		n_copy += (copy_disp === 1'b1);
		n_apply += (apply_gm === 1'b1);
		n_leave += (leave === 1'b1);
	end
	task automatic wreg(input logic [3:0] a, input logic [7:0] v);
		@(posedge clk);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rreg(input logic [3:0] a);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask
	task automatic keys(input logic [4:0] k);
		@(posedge clk);
		key <= k;
		@(posedge clk);
		key <= 5'h00;
		#1;
	endtask
	// q is request, own format, checksum ok; e is write, error
	task automatic sysex(input logic [2:0] q, input logic [1:0] e);
		@(posedge clk);
		rx <= {1'b1, q};
		#1;
		`CK({mem_wr, err_show}, e)
		@(posedge clk);
		rx <= 4'h0;
		#1;
	endtask
	task automatic run_dump();
		int n;
		n = 0;
		repeat (400) begin
			@(negedge clk);
			if (valid === 1'b1 && ready === 1'b1) begin
				`CK({groups, idx}, (n == 128) ? 8'h80 : 8'(n))
				n++;
			end
		end
		`CK(n, 129)
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	initial begin
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		repeat (20) @(posedge clk);
		`CK(role, CLDC_ROLE_MASTER)
		`CK(n_solo, 1)
		rreg(CLDC_REG_STATUS);
		`CK(d, {1'b0, CLDC_L_LINKED, CLDC_D_IDLE, CLDC_ROLE_MASTER})
		rreg(4'h9);
		`CK(d, 8'h00)
		wreg(CLDC_REG_CTRL, 8'h21);
		rreg(CLDC_REG_CTRL);
		`CK(d, 8'h21)
		m = '{8'h10, 8'h20};
		foreach (m[i]) begin
			wreg(CLDC_REG_CTRL, m[i]);
			keys(5'h19);
			`CK(valid, 1'b0)
		end
		wreg(CLDC_REG_CTRL, 8'h00);
		keys(5'h19);
		`CK(valid, 1'b1)
		fork
			run_dump();
			sysex(3'b011, 2'b00);
		join
		`CK(mute_en, 1'b1)
		`CK(auto_en, 1'b1)
		`CK(show_scene, 1'b1)
		sysex(3'b100, 2'b00);
		`CK(valid, 1'b1)
		run_dump();
		$display("test dump out done");
		m = '{8'h01, 8'h02};
		foreach (m[i]) begin
			wreg(CLDC_REG_CTRL, m[i]);
			sysex(3'b011, 2'b00);
		end
		wreg(CLDC_REG_CTRL, 8'h00);
		sysex(3'b001, 2'b00);
		rreg(CLDC_REG_STATUS);
		`CK(d[3:2], CLDC_D_IDLE)
		sysex(3'b011, 2'b10);
		sysex(3'b010, 2'b01);
		`CK(mute_en, 1'b0)
		keys(5'h19);
		`CK(valid, 1'b0)
		repeat (6) @(posedge clk);
		rreg(CLDC_REG_STATUS);
		`CK(d[3:2], CLDC_D_IN)
		repeat (20) @(posedge clk);
		rreg(CLDC_REG_STATUS);
		`CK(d[3:2], CLDC_D_IDLE)
		rreg(CLDC_REG_PKTCNT);
		`CK(d, 8'h01)
		rreg(CLDC_REG_ERRCNT);
		`CK(d, 8'h01)
		$display("test dump in done");
		n_hello = 0;
		repeat (200) @(posedge clk);
		`CK(n_hello inside {6, 7}, 1'b1)
		rreg(CLDC_REG_STATUS);
		`CK(d[6:4], CLDC_L_LINKED)
		n_solo = 0;
		wreg(CLDC_REG_CTRL, 8'h04);
		reply_en <= 1'b0;
		repeat (80) @(posedge clk);
		`CK(n_solo, 1)
		rreg(CLDC_REG_STATUS);
		`CK(d[6:4], CLDC_L_WAIT)
		repeat (120) @(posedge clk);
		`CK(role, CLDC_ROLE_STANDALONE)
		wreg(CLDC_REG_CTRL, 8'h00);
		reply_en <= 1'b1;
		n_hello = 0;
		repeat (60) @(posedge clk);
		`CK(n_hello, 0)
		`CK(role, CLDC_ROLE_STANDALONE)
		$display("test link done");
		rst_n <= 1'b0;
		to_master <= 1'b1;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		n_copy = 0;
		repeat (40) @(posedge clk);
		`CK(role, CLDC_ROLE_SLAVE)
		`CK(n_copy, 1)
		`CK(n_apply, 1)
		`CK(sync_req, 1'b0)
		`CK(auto_en, 1'b0)
		`CK(solo_en, 1'b1)
		n_reply = 0;
		repeat (100) @(posedge clk);
		`CK(n_reply > 0, 1'b1)
		n_leave = 0;
		n_copy = 0;
		reply_en <= 1'b0;
		repeat (80) @(posedge clk);
		`CK(n_leave, 1)
		reply_en <= 1'b1;
		repeat (120) @(posedge clk);
		`CK(n_copy > 0, 1'b1)
		rreg(CLDC_REG_STATUS);
		`CK(d[6:4], CLDC_L_LINKED)
		`CK(ind, 3'h0)
		keys(5'h07);
		`CK(valid, 1'b1)
		run_dump();
		$display("test slave done");
		@(posedge clk);
		rst_n <= 1'b0;
		cable <= 1'b0;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		repeat (20) @(posedge clk);
		`CK(role, CLDC_ROLE_STANDALONE)
		`CK(sync_req, 1'b0)
		rreg(CLDC_REG_STATUS);
		`CK(d[6:4], CLDC_L_ALONE)
		$display("test standalone done");
		final_report();
	end
	initial begin
		#500000;
		failures++;
		$display("watchdog expired");
		final_report();
	end
endmodule
bind cldc_top cldc_top_asserts #(.HELLO_TICKS(HELLO_TICKS),
	.TICK_DIV(TICK_DIV)) u_cldc_top_asserts (.CLK(CLK),
	.RESET_N(RESET_N), .RX_SYSEX(RX_SYSEX), .RX_DUMP_REQ(RX_DUMP_REQ),
	.RX_OWN_DUMP(RX_OWN_DUMP), .RX_CHECK_OK(RX_CHECK_OK),
	.TX_PKT_VALID(TX_PKT_VALID), .TX_PKT_GROUPS(TX_PKT_GROUPS),
	.TX_PKT_INDEX(TX_PKT_INDEX), .TX_PKT_READY(TX_PKT_READY),
	.MUTE_TX_ENABLE(MUTE_TX_ENABLE), .MIDI_RX_ENABLE(MIDI_RX_ENABLE),
	.MEM_WRITE(MEM_WRITE), .ERROR_SHOW(ERROR_SHOW),
	.SEND_HELLO(SEND_HELLO), .SEND_REPLY(SEND_REPLY),
	.SOLO_CLEAR(SOLO_CLEAR), .AUTOMATION_ENABLE(AUTOMATION_ENABLE),
	.ROLE(ROLE));
`default_nettype wire
